// >>> dv/auto_mode_ind_asserts.sv
/* Checker for the auto-mode pin block: shutdown causes, sampling pace, bus answer.
   Assumes it is bound to auto_mode_ind and sees only its ports. */
`timescale 1ns/1ps
module auto_mode_ind_asserts
  import auto_ind_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic disconnect_n,
  input wire logic uart_cmd_valid,
  input wire logic battery_low_flag_pin,
  input wire logic link_quality_pin,
  input wire logic radio_en,
  input wire logic uart_en,
  input wire logic uart_cmd_accept
);
  localparam int unsigned BGAP = BAT_UNIT_MS * TICK_CYCLES - 1;  // Least sample gap
  localparam int unsigned LGAP = LQ_MIN_MS * TICK_CYCLES - 1;    // Least link cycle
  logic [31:0] dlow_r;  // Cycles disconnect held low
  logic [31:0] bgap_r;  // Cycles since battery pin moved
  logic        bpin_r;  // Battery pin one cycle ago
  logic [31:0] lgap_r;  // Cycles since link pin rose
  logic        lpin_r;  // Link pin one cycle ago
  // Hold and gap counters
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dlow_r <= 32'h0;
      bgap_r <= 32'h4000_0000;
      bpin_r <= 1'b1;
      lgap_r <= 32'h4000_0000;
      lpin_r <= 1'b0;
    end else begin
      dlow_r <= disconnect_n ? 32'h0 : dlow_r + 32'h1;
      bgap_r <= (battery_low_flag_pin != bpin_r) ? 32'h1 : bgap_r + 32'h1;
      bpin_r <= battery_low_flag_pin;
      lgap_r <= (link_quality_pin && !lpin_r) ? 32'h1 : lgap_r + 32'h1;
      lpin_r <= link_quality_pin;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_drop_hold: assert property (
    $fell(radio_en) |-> dlow_r >= 9 * TICK_CYCLES || !battery_low_flag_pin)
    else $error("radio off without cause");
  a_shut_uart: assert property (!radio_en |-> !uart_en)
    else $error("uart on in shutdown");
  a_cmd_cause: assert property (uart_cmd_accept |-> $past(uart_cmd_valid))
    else $error("accept without message");
  a_shut_no_cmd: assert property (uart_cmd_accept |-> uart_en)
    else $error("accept in shutdown");
  a_batt_rate: assert property (
    $changed(battery_low_flag_pin) |-> bgap_r >= BGAP)
    else $error("battery pin moved off grid");
  a_lq_off: assert property (
    !radio_en && !$past(radio_en) |-> !link_quality_pin)
    else $error("link pin high in shutdown");
  a_lq_pace: assert property (
    $rose(link_quality_pin) |-> lgap_r >= LGAP)
    else $error("link pin rose off pace");
  a_zero_wait: assert property ($past(hreadyout) |-> hreadyout)
    else $error("wait state inserted");
  a_bus_okay: assert property (hreadyout |-> !hresp)
    else $error("error response");
endmodule : auto_mode_ind_asserts

bind auto_mode_ind auto_mode_ind_asserts #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .mclk(mclk), .nrst(nrst), .hreadyout(hreadyout), .hresp(hresp),
  .disconnect_n(disconnect_n), .uart_cmd_valid(uart_cmd_valid),
  .battery_low_flag_pin(battery_low_flag_pin), .link_quality_pin(link_quality_pin),
  .radio_en(radio_en), .uart_en(uart_en), .uart_cmd_accept(uart_cmd_accept)
);

// >>> dv/auto_mode_ind_test.sv
/* Testbench: battery and link rows, then command, drop, shutdown, reset cases.
   Assumes host_pins drives the pins and 4 cycles to the ms. */
`timescale 1ns/1ps
module auto_mode_ind_test
  import auto_ind_pkg::*;
;
  localparam int unsigned TK = 4;  // Cycles per ms
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q;
  logic        hreadyout, hresp, dn, cv, bp, lp, radio_en, uart_en, acc;
  logic [7:0]  bat;
  int          n_fail = 0, checked = 0, n_acc = 0;
  // Battery, strength, battery pin, link pin
  localparam logic [17:0] ROWS [8] = '{{8'h14, 8'h55, 2'b11}, {8'h0b, 8'h45, 2'b11},
    {8'h09, 8'h3c, 2'b00}, {8'h0b, 8'h45, 2'b00}, {8'h0c, 8'h50, 2'b11},
    {8'h09, 8'h3f, 2'b00}, {8'h0a, 8'h40, 2'b00}, {8'h12, 8'h5a, 2'b11}};
  localparam logic [31:0] FLOW [3] = '{32'h05, 32'h15, 32'h25};
  localparam logic [7:0] RADR [4] = '{CTRL_OFS, BATCFG_OFS, LQCFG_OFS, 8'h14};
  localparam logic [31:0] RVAL [4] = '{CTRL_RST, BATCFG_RST, LQCFG_RST, 32'h0};

  always #25 mclk = ~mclk;
  // Count accepted messages
  always @(posedge mclk) if (acc === 1'b1) n_acc++;

  auto_mode_ind #(.TICK_CYCLES(TK)) uut (
    .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .disconnect_n(dn),
    .battery_sense_input(bat), .uart_cmd_valid(cv), .battery_low_flag_pin(bp),
    .link_quality_pin(lp), .radio_en(radio_en), .uart_en(uart_en), .uart_cmd_accept(acc));
  host_pins #(.TICK_CYCLES(TK)) host (
    .mclk(mclk), .disconnect_n(dn), .battery_sense_input(bat), .uart_cmd_valid(cv));

  // One single AHB transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: word %h want %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: pin %b want %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  initial begin
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    while (hreadyout !== 1'b1) @(posedge mclk);
    xfer(1'b1, BATCFG_OFS, 32'h000c_0a01, q);
    xfer(1'b1, LQCFG_OFS, 32'h0000_4050, q);
    xfer(1'b1, CTRL_OFS, 32'h0000_0007, q);
    for (int i = 0; i < 8; i++) begin
      host.batt(ROWS[i][17:10]);
      xfer(1'b1, SAMPLE_OFS, {16'h0, ROWS[i][9:2], 8'h00}, q);
      repeat (700) @(posedge mclk);
      chk_bit(bp, ROWS[i][1]);
      chk_bit(lp, ROWS[i][0]);
    end
    $display("rows done");
    xfer(1'b1, CTRL_OFS, 32'h0000_0005, q);
    repeat (240) @(posedge mclk);
    chk_bit(lp, 1'b0);
    host.cmd();
    repeat (3) @(posedge mclk);
    chk_word(32'(n_acc), 32'h0);
    xfer(1'b1, CTRL_OFS, 32'h0000_0004, q);
    host.cmd();
    repeat (3) @(posedge mclk);
    chk_word(32'(n_acc), 32'h1);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, CTRL_OFS, FLOW[i], q);
      host.drop(i == 0 ? 5 : 12);
      repeat (8) @(posedge mclk);
      chk_bit(radio_en, 1'b1);
    end
    xfer(1'b1, CTRL_OFS, 32'h0000_0005, q);
    host.drop(12);
    repeat (8) @(posedge mclk);
    chk_bit(uart_en, 1'b0);
    xfer(1'b0, STATUS_OFS, 32'h0, q);
    chk_word(q & 32'h3, 32'h2);
    xfer(1'b1, CTRL_OFS, 32'h0000_0009, q);
    repeat (10) @(posedge mclk);
    chk_bit(radio_en, 1'b1);
    xfer(1'b1, BATCFG_OFS, 32'h010c_0a01, q);
    host.batt(8'h05);
    repeat (2000) @(posedge mclk);
    chk_bit(radio_en, 1'b1);
    repeat (1400) @(posedge mclk);
    chk_bit(radio_en, 1'b0);
    host.batt(8'h14);
    $display("sequence done");
    nrst <= 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    while (hreadyout !== 1'b1) @(posedge mclk);
    xfer(1'b1, 8'h14, 32'hffff_ffff, q);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, RADR[i], 32'h0, q);
      chk_word(q, RVAL[i]);
    end
    $display("reset done");
    // Out-of-range thresholds are clamped
    xfer(1'b1, BATCFG_OFS, 32'h0030_2001, q);
    xfer(1'b1, LQCFG_OFS, 32'h0000_1060, q);
    xfer(1'b1, CTRL_OFS, 32'h0000_0007, q);
    host.batt(8'h11);
    xfer(1'b1, SAMPLE_OFS, 32'h0000_5a00, q);
    repeat (700) @(posedge mclk);
    chk_bit(bp, 1'b0);
    chk_bit(lp, 1'b1);
    host.batt(8'h13);
    xfer(1'b1, SAMPLE_OFS, 32'h0000_3100, q);
    repeat (700) @(posedge mclk);
    chk_bit(bp, 1'b1);
    chk_bit(lp, 1'b0);
    $display("clamp done");
    results();
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    results();
  end
endmodule : auto_mode_ind_test

// >>> dv/host_pins.sv
/* Host model: drives the disconnect pin, battery level and command strobe.
   Assumes mclk and TICK_CYCLES clock cycles to the ms. */
`timescale 1ns/1ps
module host_pins #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock
  input  wire logic       mclk,
  // Pins toward the module
  output logic            disconnect_n,
  output logic [7:0]      battery_sense_input,
  output logic            uart_cmd_valid
);
  // Idle levels
  initial begin
    disconnect_n = 1'b1;
    battery_sense_input = 8'h14;
    uart_cmd_valid = 1'b0;
  end
  task automatic drop(input int unsigned ms);
    @(posedge mclk);
    disconnect_n <= 1'b0;
    repeat (ms * TICK_CYCLES) @(posedge mclk);
    disconnect_n <= 1'b1;
  endtask : drop
  // New battery level
  task automatic batt(input logic [7:0] v);
    @(posedge mclk);
    battery_sense_input <= v;
  endtask : batt
  // One message strobe
  task automatic cmd();
    @(posedge mclk);
    uart_cmd_valid <= 1'b1;
    @(posedge mclk);
    uart_cmd_valid <= 1'b0;
  endtask : cmd
endmodule : host_pins

// >>> hdl/auto_mode_ind.sv
/*
  Auto-mode pin logic: forced disconnect input, low battery indicator,
  link quality indicator, with configuration over AHB-Lite.
  Assumes inputs synchronous to mclk, one AHB master, and that the
  battery and signal-strength figures come from converters elsewhere.
*/
// Operation
// - Held disconnect in link drops to shutdown
// - Shutdown stops radio and UART until wake
// - Sample below low threshold drives indicator 0
// - Sample at/above normal threshold drives 1
// - Low battery for field*640 ms shuts down
// - Battery sampled every field*80 ms
// - Battery thresholds are field*100 mV, max 0x12
// - Link quality pin driven only when enabled
// - Link thresholds accept 0x32 to 0x5a dB
// - Link quality cycle no faster than 25 ms
// - Auto mode ignores UART command messages
// - Flow-control pins usable only if disabled
`timescale 1ns/1ps
module auto_mode_ind
  import auto_ind_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_MS_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pins and converter inputs
  input  wire logic        disconnect_n,
  input  wire logic [7:0]  battery_sense_input,
  input  wire logic        uart_cmd_valid,
  // Indicator and control outputs
  output logic             battery_low_flag_pin,
  output logic             link_quality_pin,
  output logic             radio_en,
  output logic             uart_en,
  output logic             uart_cmd_accept
);

  // Disconnect hold time in ms, taken from the package
  localparam int unsigned HOLD_MS = DISCONNECT_HOLD_TIME_MS;

  // Reset synchroniser
  logic rst_s1_r;
  logic rst_n_r;

  // Register file
  logic [31:0] ctrl_r;
  logic [31:0] batcfg_r;
  logic [31:0] lqcfg_r;
  logic [7:0]  rssi_r;

  // AHB data-phase capture
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] hrdata_r;

  // Timebase and counters
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_r;
  logic        tick_ms;
  logic [15:0] bat_ms_r;
  logic [19:0] low_ms_r;
  logic [4:0]  hold_ms_r;
  logic [4:0]  lq_ms_r;

  // State and outputs
  op_state_t   state_r;
  op_state_t   state_nxt;
  ind_pins_t   pins_r;
  logic        cmd_acc_r;

  // Clamp a battery level to its top
  function automatic logic [7:0] clamp_bat(input logic [7:0] v);
    clamp_bat = (v > BAT_LVL_MAX) ? BAT_LVL_MAX : v;
  endfunction : clamp_bat

  // Clamp a signal-strength threshold into range
  function automatic logic [7:0] clamp_lq(input logic [7:0] v);
    clamp_lq = (v < LQ_MIN_VAL) ? LQ_MIN_VAL : ((v > LQ_MAX_VAL) ? LQ_MAX_VAL : v);
  endfunction : clamp_lq

  // Release reset through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Decoded configuration fields
  wire         auto_mode   = ctrl_r[CTRL_AUTO_BIT];
  wire         lq_enable   = ctrl_r[CTRL_LQEN_BIT];
  wire         link_up     = ctrl_r[CTRL_LINK_BIT];
  wire         wake_req    = ctrl_r[CTRL_WAKE_BIT];
  wire         cts_on      = ctrl_r[CTRL_CTS_BIT];
  wire         rts_on      = ctrl_r[CTRL_RTS_BIT];
  wire [7:0]   bat_intv    = batcfg_r[BAT_INTV_LSB +: 8];
  // Battery levels in 100 mV units and link thresholds clamped; shutdown field not
  wire [7:0]   bat_low     = clamp_bat(batcfg_r[BAT_LOW_LSB +: 8]);
  wire [7:0]   bat_norm    = clamp_bat(batcfg_r[BAT_NORM_LSB +: 8]);
  wire [7:0]   bat_shut    = batcfg_r[BAT_SHUT_LSB +: 8];
  wire [7:0]   lq_good     = clamp_lq(lqcfg_r[LQ_GOOD_LSB +: 8]);
  wire [7:0]   lq_poor     = clamp_lq(lqcfg_r[LQ_POOR_LSB +: 8]);
  // Interval zero treated as one unit
  wire [7:0]   bat_units   = (bat_intv == 8'h00) ? 8'h01 : bat_intv;
  wire [15:0]  bat_period  = 16'(bat_units * BAT_UNIT_MS);
  wire [19:0]  shut_period = 20'(bat_shut * SHUT_UNIT_MS);

  // AHB address-phase decode
  wire         ahb_go      = hsel && hready && htrans[1];
  wire         ahb_wr      = ahb_go && hwrite;
  wire         ahb_rd      = ahb_go && !hwrite;
  wire [31:0]  sample_word = {16'h0000, rssi_r, battery_sense_input};
  wire [31:0]  status_word = {24'h000000, 2'b00, cmd_acc_r, pins_r.link_quality_pin,
                              pins_r.battery_low_flag_pin, 1'b0, 2'(state_r)};
  wire [31:0]  rd_mux      = (haddr == CTRL_OFS)   ? ctrl_r   :
                             (haddr == BATCFG_OFS) ? batcfg_r :
                             (haddr == LQCFG_OFS)  ? lqcfg_r  :
                             (haddr == SAMPLE_OFS) ? sample_word :
                             (haddr == STATUS_OFS) ? status_word : 32'h0000_0000;

  // Millisecond tick
  assign tick_ms = (tick_cnt_r == ($bits(tick_cnt_r))'(TICK_CYCLES - 1));

  // Event terms
  wire bat_sample   = tick_ms && (bat_ms_r >= bat_period - 16'h0001);
  wire bat_is_low   = (battery_sense_input < bat_low);
  wire bat_is_norm  = (battery_sense_input >= bat_norm);
  // Hold must reach the least time
  wire hold_done    = (hold_ms_r >= 5'(HOLD_MS));
  // Disconnect pin counts only without flow control
  wire disc_active  = !disconnect_n && !(cts_on || rts_on);
  wire low_expired  = (bat_shut != 8'h00) && (low_ms_r >= shut_period);
  // One link quality cycle per 25 ms at most
  wire lq_slot      = tick_ms && (lq_ms_r >= 5'(LQ_MIN_MS - 1));

  // Next operating state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY: begin
        if (low_expired) state_nxt = ST_SHUTDOWN;
        else if (link_up) state_nxt = ST_LINK;
      end
      ST_LINK: begin
        if (hold_done || low_expired) state_nxt = ST_SHUTDOWN;
        else if (!link_up) state_nxt = ST_STANDBY;
      end
      ST_SHUTDOWN: begin
        if (wake_req) state_nxt = ST_STANDBY;
      end
      default: state_nxt = ST_STANDBY;
    endcase
  end

  // Register writes, one cycle after the address phase
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      ctrl_r    <= CTRL_RST;
      batcfg_r  <= BATCFG_RST;
      lqcfg_r   <= LQCFG_RST;
    end else begin
      wr_pend_r <= ahb_wr;
      if (ahb_wr) wr_addr_r <= haddr;
      if (wr_pend_r && wr_addr_r == CTRL_OFS) ctrl_r <= hwdata;
      else if (state_r == ST_SHUTDOWN && wake_req) ctrl_r[CTRL_WAKE_BIT] <= 1'b0;
      if (wr_pend_r && wr_addr_r == BATCFG_OFS) batcfg_r <= hwdata;
      if (wr_pend_r && wr_addr_r == LQCFG_OFS) lqcfg_r <= hwdata;
    end
  end

  // Signal-strength sample and read data
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rssi_r   <= RSSI_RST;
      hrdata_r <= 32'h0000_0000;
    end else begin
      if (wr_pend_r && wr_addr_r == SAMPLE_OFS) rssi_r <= hwdata[SMP_RSSI_LSB +: 8];
      if (ahb_rd) hrdata_r <= rd_mux;
    end
  end

  // Timebase and period counters
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tick_cnt_r <= '0;
      bat_ms_r   <= 16'h0000;
      lq_ms_r    <= 5'h00;
    end else begin
      tick_cnt_r <= tick_ms ? '0 : tick_cnt_r + 1'b1;
      if (tick_ms) bat_ms_r <= bat_sample ? 16'h0000 : bat_ms_r + 16'h0001;
      if (tick_ms) lq_ms_r <= lq_slot ? 5'h00 : lq_ms_r + 5'h01;
    end
  end

  // Disconnect hold and low-battery time counters
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_ms_r <= 5'h00;
      low_ms_r  <= 20'h00000;
    end else begin
      if (!disc_active || state_r != ST_LINK) hold_ms_r <= 5'h00;
      else if (tick_ms && !hold_done) hold_ms_r <= hold_ms_r + 5'h01;
      // Restarted when a sample sees the battery at or above low
      if (state_r == ST_SHUTDOWN || (bat_sample && !bat_is_low)) low_ms_r <= 20'h00000;
      else if (tick_ms && !pins_r.battery_low_flag_pin && !low_expired)
        low_ms_r <= low_ms_r + 20'h00001;
    end
  end

  // State and indicator outputs
  always_ff @(posedge mclk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r   <= ST_STANDBY;
      pins_r    <= '{battery_low_flag_pin: 1'b1, link_quality_pin: 1'b0,
                     radio_en: 1'b1, uart_en: 1'b1};
      cmd_acc_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // Radio and UART off in shutdown
      pins_r.radio_en <= (state_nxt != ST_SHUTDOWN);
      pins_r.uart_en  <= (state_nxt != ST_SHUTDOWN);
      if (bat_sample && bat_is_low) pins_r.battery_low_flag_pin <= 1'b0;
      else if (bat_sample && bat_is_norm) pins_r.battery_low_flag_pin <= 1'b1;
      // Link quality only when enabled and linked
      if (!lq_enable || state_r != ST_LINK) pins_r.link_quality_pin <= 1'b0;
      else if (lq_slot && rssi_r >= lq_good) pins_r.link_quality_pin <= 1'b1;
      else if (lq_slot && rssi_r < lq_poor) pins_r.link_quality_pin <= 1'b0;
      // Command messages ignored in auto mode
      cmd_acc_r <= uart_cmd_valid && !auto_mode && (state_nxt != ST_SHUTDOWN);
    end
  end

  // Output drive
  assign hrdata               = hrdata_r;
  assign hreadyout            = rst_n_r;
  assign hresp                = 1'b0;
  assign battery_low_flag_pin = pins_r.battery_low_flag_pin;
  assign link_quality_pin     = pins_r.link_quality_pin;
  assign radio_en             = pins_r.radio_en;
  assign uart_en              = pins_r.uart_en;
  assign uart_cmd_accept      = cmd_acc_r;

endmodule : auto_mode_ind

// >>> shared/auto_ind_pkg.sv
/*
  Package for the auto-mode indication and link-drop block.
  Holds register offsets, field layouts, reset values and timing counts.
  Assumes a 20 MHz system clock.
*/
package auto_ind_pkg;

  // Clock rate in kHz
  localparam int unsigned CLK_KHZ = 20000;

  // Timebase: 1 ms tick
  localparam int unsigned TICK_MS_CYCLES = CLK_KHZ;
  // Least hold of the disconnect request, ms
  localparam int unsigned DISCONNECT_HOLD_TIME_MS = 10;
  // Battery detection unit, ms
  localparam int unsigned BAT_UNIT_MS = 80;
  // Low battery into shutdown unit, ms
  localparam int unsigned SHUT_UNIT_MS = 640;
  // Least time of one link quality cycle, ms
  localparam int unsigned LQ_MIN_MS = 25;

  // Register byte addresses
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] BATCFG_OFS = 8'h04;
  localparam logic [7:0] LQCFG_OFS  = 8'h08;
  localparam logic [7:0] SAMPLE_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Control fields
  localparam int unsigned CTRL_AUTO_BIT  = 0;
  localparam int unsigned CTRL_LQEN_BIT  = 1;
  localparam int unsigned CTRL_LINK_BIT  = 2;
  localparam int unsigned CTRL_WAKE_BIT  = 3;
  localparam int unsigned CTRL_CTS_BIT   = 4;
  localparam int unsigned CTRL_RTS_BIT   = 5;

  // Battery config fields
  localparam int unsigned BAT_INTV_LSB = 0;
  localparam int unsigned BAT_LOW_LSB  = 8;
  localparam int unsigned BAT_NORM_LSB = 16;
  localparam int unsigned BAT_SHUT_LSB = 24;

  // Link quality config fields
  localparam int unsigned LQ_GOOD_LSB = 0;
  localparam int unsigned LQ_POOR_LSB = 8;

  // Sample register fields
  localparam int unsigned SMP_RSSI_LSB = 8;

  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
  localparam logic [31:0] BATCFG_RST = 32'h0021_1e01;
  localparam logic [31:0] LQCFG_RST  = 32'h0000_5a46;
  localparam logic [7:0]  RSSI_RST   = 8'h5a;

  // Limits of configured values
  localparam logic [7:0] BAT_LVL_MAX = 8'h12;
  localparam logic [7:0] LQ_MIN_VAL  = 8'h32;
  localparam logic [7:0] LQ_MAX_VAL  = 8'h5a;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // Main operating state
  typedef enum logic [1:0] {
    ST_STANDBY,
    ST_LINK,
    ST_SHUTDOWN
  } op_state_t;

  // Pin function outputs travel together
  typedef struct packed {
    logic battery_low_flag_pin;
    logic link_quality_pin;
    logic radio_en;
    logic uart_en;
  } ind_pins_t;

endpackage : auto_ind_pkg
